/* File: verilog/pscr_pkg.sv */
// Package of constants and types for the stamp configuration register bank
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package pscr_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_RELOAD_HIGH = 12'h184;
    localparam logic [11:0] OFF_RELOAD_LOW = 12'h188;
    localparam logic [11:0] OFF_ADDR_UPPER = 12'h18C;
    localparam logic [11:0] OFF_ADDR_LOWER = 12'h190;
    localparam logic [11:0] OFF_CONFIG = 12'h194;
    localparam logic [11:0] OFF_TARGET_HIGH = 12'h17C;
    localparam logic [11:0] OFF_TARGET_LOW = 12'h180;
    localparam logic [11:0] OFF_STATUS = 12'h1A0;
    // Configuration field positions
    localparam int CFG_MASTER = 31;
    localparam int CFG_PRI = 30;
    localparam int CFG_ALT_A = 29;
    localparam int CFG_ALT_B = 28;
    localparam int CFG_ALT_C = 27;
    localparam int CFG_USER = 26;
    localparam int CFG_LOCK_RX = 25;
    localparam int CFG_LOCK_TX = 24;
    localparam int CFG_RELOAD_ADD = 0;
    // Port 2 field mask and reset value
    localparam logic [31:0] CFG_MASK = 32'hFF000001;
    localparam logic [31:0] CFG_RESET = 32'h43000000;
    localparam logic [15:0] UPPER_MASK = 16'hFFFF;
    // Fixed multicast PTP addresses
    localparam logic [47:0] ADDR_PRI = 48'h01005E000181;
    localparam logic [47:0] ADDR_ALT_A = 48'h01005E000182;
    localparam logic [47:0] ADDR_ALT_B = 48'h01005E000183;
    localparam logic [47:0] ADDR_ALT_C = 48'h01005E000184;
    // Message kinds
    typedef enum logic [1:0] {
        MSG_SYNC = 2'b00,
        MSG_DELAY_REQ = 2'b01,
        MSG_OTHER = 2'b10
    } pscr_msg_type;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/pscr_match.sv */
// Destination address filter for Port 2 frames
`timescale 1ns/1ns
`default_nettype none
module pscr_match (
    input wire logic [47:0] dest,
    input wire logic [31:0] cfg,
    input wire logic [47:0] user_addr,
    output logic hit
);
    import pscr_pkg::*;
    // Any enabled address match makes the frame a candidate
    always_comb begin
        hit = 1'b0;
        if (cfg[CFG_PRI] && dest == ADDR_PRI) hit = 1'b1;
        if (cfg[CFG_ALT_A] && dest == ADDR_ALT_A) hit = 1'b1;
        if (cfg[CFG_ALT_B] && dest == ADDR_ALT_B) hit = 1'b1;
        if (cfg[CFG_ALT_C] && dest == ADDR_ALT_C) hit = 1'b1;
        if (cfg[CFG_USER] && dest == user_addr) hit = 1'b1;
    end
endmodule
`default_nettype wire

/* File: verilog/pscr_top.sv */
// Stamp configuration registers with Port 2 capture and target compare
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pscr_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [63:0] TS_CLOCK,
    input wire logic FRAME_VALID,
    input wire logic FRAME_TX,
    input wire logic [1:0] FRAME_KIND,
    input wire logic [47:0] FRAME_DEST,
    input wire logic [79:0] FRAME_SRC_ID,
    input wire logic [15:0] FRAME_SEQ,
    input wire logic RX_PEND_CLR,
    input wire logic TX_PEND_CLR,
    output logic RX_PEND,
    output logic TX_PEND,
    output logic [63:0] RX_CAP_CLOCK,
    output logic [79:0] RX_CAP_ID,
    output logic [15:0] RX_CAP_SEQ,
    output logic [63:0] TX_CAP_CLOCK,
    output logic [79:0] TX_CAP_ID,
    output logic [15:0] TX_CAP_SEQ,
    output logic COMPARE_EVENT
);
    import pscr_pkg::*;

    // -------------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------------
    logic [31:0] reload_high_r; // Staged upper half
    logic [31:0] reload_low_r; // Staged lower half
    logic [63:0] reload_eff_r; // Effective reload value
    logic [1:0] reload_seen_r; // Halves written since last commit
    logic [31:0] target_high_r; // Staged target upper
    logic [31:0] target_low_r; // Staged target lower
    logic [1:0] target_seen_r; // Target halves written
    logic [63:0] compare_r; // Live compare value
    logic [15:0] addr_upper_r; // User address top bits
    logic [31:0] addr_lower_r; // User address low bits
    logic [31:0] cfg_r; // Configuration
    logic [47:0] user_addr; // Joined user address
    logic cand; // Frame matches an enabled address

    // -------------------------------------------------------------------------
    // AXI4-Lite handshake state
    // -------------------------------------------------------------------------
    logic aw_held_r; // Write address accepted
    logic w_held_r; // Write data accepted
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go; // Both parts present, response free
    logic [31:0] rd_val; // Decoded read value
    logic rd_ok; // Read hits a mapped register
    logic wr_ok; // Write hits a mapped register

    // Byte-lane merge shared by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
        end
        return res;
    endfunction

    assign wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
    assign user_addr = {addr_upper_r, addr_lower_r};
    assign wr_ok = awaddr_r == OFF_RELOAD_HIGH || awaddr_r == OFF_RELOAD_LOW ||
                   awaddr_r == OFF_ADDR_UPPER || awaddr_r == OFF_ADDR_LOWER ||
                   awaddr_r == OFF_CONFIG || awaddr_r == OFF_TARGET_HIGH ||
                   awaddr_r == OFF_TARGET_LOW;

    // Address and data taken independently, in either order
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_held_r && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_held_r && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                awaddr_r <= {S_AXI_AWADDR[11:2], 2'b00};
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response, error for unmapped offsets
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Plain registers: user address and configuration
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            addr_upper_r <= 16'h0000;
            addr_lower_r <= 32'h00000000;
            cfg_r <= CFG_RESET;
        end else if (wr_go) begin
            // Only the low 16 bits are stored; upper bits never change
            if (awaddr_r == OFF_ADDR_UPPER)
                addr_upper_r <= 16'(merge({16'h0000, addr_upper_r}, wdata_r, wstrb_r));
            if (awaddr_r == OFF_ADDR_LOWER)
                addr_lower_r <= merge(addr_lower_r, wdata_r, wstrb_r);
            if (awaddr_r == OFF_CONFIG)
                cfg_r <= merge(cfg_r, wdata_r, wstrb_r) & CFG_MASK;
        end
    end

    // Reload halves commit together once both have been written
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            reload_high_r <= 32'h00000000;
            reload_low_r <= 32'h00000000;
            reload_seen_r <= 2'b00;
            reload_eff_r <= 64'h0;
        end else if (wr_go) begin
            if (awaddr_r == OFF_RELOAD_HIGH) begin
                reload_high_r <= merge(reload_high_r, wdata_r, wstrb_r);
                if (reload_seen_r[0]) begin
                    reload_eff_r <= {merge(reload_high_r, wdata_r, wstrb_r), reload_low_r};
                    reload_seen_r <= 2'b00;
                end else begin
                    reload_seen_r[1] <= 1'b1;
                end
            end
            if (awaddr_r == OFF_RELOAD_LOW) begin
                reload_low_r <= merge(reload_low_r, wdata_r, wstrb_r);
                if (reload_seen_r[1]) begin
                    reload_eff_r <= {reload_high_r, merge(reload_low_r, wdata_r, wstrb_r)};
                    reload_seen_r <= 2'b00;
                end else begin
                    reload_seen_r[0] <= 1'b1;
                end
            end
        end
    end

    // Compare value: software pair write, or update on a compare event
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            target_high_r <= 32'h00000000;
            target_low_r <= 32'h00000000;
            target_seen_r <= 2'b00;
            compare_r <= 64'h0;
        end else begin
            if (wr_go && awaddr_r == OFF_TARGET_HIGH) begin
                target_high_r <= merge(target_high_r, wdata_r, wstrb_r);
                target_seen_r[1] <= 1'b1;
            end
            if (wr_go && awaddr_r == OFF_TARGET_LOW) begin
                target_low_r <= merge(target_low_r, wdata_r, wstrb_r);
                target_seen_r[0] <= 1'b1;
            end
            if (target_seen_r == 2'b11) begin
                compare_r <= {target_high_r, target_low_r};
                target_seen_r <= 2'b00;
            end else if (TS_CLOCK == compare_r) begin
                compare_r <= cfg_r[CFG_RELOAD_ADD] ? reload_eff_r : compare_r + reload_eff_r;
            end
        end
    end

    // Match pulse toward the interrupt logic
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) COMPARE_EVENT <= 1'b0;
        else COMPARE_EVENT <= TS_CLOCK == compare_r;
    end

    // -------------------------------------------------------------------------
    // Port 2 capture
    // -------------------------------------------------------------------------
    pscr_match u_match (
        .dest(FRAME_DEST),
        .cfg(cfg_r),
        .user_addr(user_addr),
        .hit(cand)
    );

    logic want_tx; // Transmit frame of the captured kind
    logic want_rx; // Receive frame of the captured kind
    always_comb begin
        want_tx = 1'b0;
        want_rx = 1'b0;
        if (FRAME_VALID && cand) begin
            if (cfg_r[CFG_MASTER]) begin
                want_tx = FRAME_TX && FRAME_KIND == MSG_SYNC;
                want_rx = !FRAME_TX && FRAME_KIND == MSG_DELAY_REQ;
            end else begin
                want_tx = FRAME_TX && FRAME_KIND == MSG_DELAY_REQ;
                want_rx = !FRAME_TX && FRAME_KIND == MSG_SYNC;
            end
        end
    end

    // Receive capture, held while locked and pending; set beats clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            RX_PEND <= 1'b0;
            RX_CAP_CLOCK <= 64'h0;
            RX_CAP_ID <= 80'h0;
            RX_CAP_SEQ <= 16'h0000;
        end else begin
            if (want_rx && !(cfg_r[CFG_LOCK_RX] && RX_PEND)) begin
                RX_CAP_CLOCK <= TS_CLOCK;
                RX_CAP_ID <= FRAME_SRC_ID;
                RX_CAP_SEQ <= FRAME_SEQ;
            end
            if (want_rx) RX_PEND <= 1'b1;
            else if (RX_PEND_CLR) RX_PEND <= 1'b0;
        end
    end

    // Transmit capture, same lock scheme
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            TX_PEND <= 1'b0;
            TX_CAP_CLOCK <= 64'h0;
            TX_CAP_ID <= 80'h0;
            TX_CAP_SEQ <= 16'h0000;
        end else begin
            if (want_tx && !(cfg_r[CFG_LOCK_TX] && TX_PEND)) begin
                TX_CAP_CLOCK <= TS_CLOCK;
                TX_CAP_ID <= FRAME_SRC_ID;
                TX_CAP_SEQ <= FRAME_SEQ;
            end
            if (want_tx) TX_PEND <= 1'b1;
            else if (TX_PEND_CLR) TX_PEND <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------------
    always_comb begin
        rd_ok = 1'b1;
        case ({S_AXI_ARADDR[11:2], 2'b00})
            OFF_RELOAD_HIGH: rd_val = reload_high_r;
            OFF_RELOAD_LOW: rd_val = reload_low_r;
            OFF_TARGET_HIGH: rd_val = target_high_r;
            OFF_TARGET_LOW: rd_val = target_low_r;
            OFF_ADDR_UPPER: rd_val = {16'h0000, addr_upper_r};
            OFF_ADDR_LOWER: rd_val = addr_lower_r;
            OFF_CONFIG: rd_val = cfg_r;
            OFF_STATUS: rd_val = {29'h0, COMPARE_EVENT, TX_PEND, RX_PEND};
            default: begin
                rd_val = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Address taken in one cycle, data the next
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_val;
                S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_rx_lock_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        RX_PEND && cfg_r[CFG_LOCK_RX] && !RX_PEND_CLR |=> $stable(RX_CAP_CLOCK))
        else $error("rx capture overwritten while locked");
    a_tx_lock_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        TX_PEND && cfg_r[CFG_LOCK_TX] && !TX_PEND_CLR |=> $stable(TX_CAP_SEQ))
        else $error("tx capture overwritten while locked");
    a_reload_pair: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !(wr_go && awaddr_r == OFF_RELOAD_HIGH && reload_seen_r[0]) &&
        !(wr_go && awaddr_r == OFF_RELOAD_LOW && reload_seen_r[1]) |=> $stable(reload_eff_r))
        else $error("reload changed without paired write");
    a_upper_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
        S_AXI_ARVALID && S_AXI_ARREADY && {S_AXI_ARADDR[11:2], 2'b00} == OFF_ADDR_UPPER
        |=> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("reserved address bits read nonzero");
    a_master_tx: assert property (@(posedge CLOCK) disable iff (!RSTN)
        FRAME_VALID && cand && cfg_r[CFG_MASTER] && FRAME_TX && FRAME_KIND == MSG_SYNC
        |=> TX_PEND)
        else $error("master sync tx not flagged");
    a_slave_rx: assert property (@(posedge CLOCK) disable iff (!RSTN)
        FRAME_VALID && cand && !cfg_r[CFG_MASTER] && !FRAME_TX && FRAME_KIND == MSG_SYNC
        |=> RX_PEND)
        else $error("slave sync rx not flagged");
    a_no_candidate: assert property (@(posedge CLOCK) disable iff (!RSTN)
        cfg_r[CFG_PRI:CFG_USER] == 5'b00000 && !RX_PEND |=> !RX_PEND)
        else $error("capture without enabled address");
    a_compare_ev: assert property (@(posedge CLOCK) disable iff (!RSTN)
        TS_CLOCK == compare_r |=> COMPARE_EVENT)
        else $error("match not signalled");
    a_reload_mode: assert property (@(posedge CLOCK) disable iff (!RSTN)
        TS_CLOCK == compare_r && target_seen_r != 2'b11 && cfg_r[CFG_RELOAD_ADD]
        |=> compare_r == $past(reload_eff_r))
        else $error("reload not applied");
endmodule
`default_nettype wire

/* File: test/pscr_frame_src.sv */
// Switch port frame traffic model feeding Port 2 frame events
`timescale 1ns/1ns
`default_nettype none
module pscr_frame_src (
    input wire logic CLOCK,
    output logic FRAME_VALID,
    output logic FRAME_TX,
    output logic [1:0] FRAME_KIND,
    output logic [47:0] FRAME_DEST,
    output logic [79:0] FRAME_SRC_ID,
    output logic [15:0] FRAME_SEQ
);
    import pscr_pkg::*;
    // ----------------------------------------
    // Idle state at time zero
    // ----------------------------------------
    initial begin
        FRAME_VALID = 1'h0;
        FRAME_TX = 1'h0;
        FRAME_KIND = 2'h3;
        FRAME_DEST = 48'h0;
        FRAME_SRC_ID = 80'h0;
        FRAME_SEQ = 16'h0;
    end
    // One frame event; fields go to their inverse afterwards so stale data never matches
    task automatic send(input logic tx, input logic [1:0] k, input logic [47:0] d,
                        input logic [15:0] s);
        @(posedge CLOCK);
        FRAME_VALID <= 1'h1;
        FRAME_TX <= tx;
        FRAME_KIND <= k;
        FRAME_DEST <= d;
        FRAME_SRC_ID <= {5{s}};
        FRAME_SEQ <= s;
        @(posedge CLOCK);
        FRAME_VALID <= 1'h0;
        FRAME_TX <= ~tx;
        FRAME_KIND <= ~k;
        FRAME_DEST <= ~d;
        FRAME_SRC_ID <= ~{5{s}};
        FRAME_SEQ <= ~s;
    endtask
endmodule
`default_nettype wire

/* File: test/pscr_top_tb.sv */
// Self-checking bench for the stamp configuration register bank
`timescale 1ns/1ns
`default_nettype none
module pscr_top_tb;
    import pscr_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic CLOCK = 1'h0;
    logic RSTN = 1'h0;
    logic [11:0] S_AXI_AWADDR = 12'h0;
    logic S_AXI_AWVALID = 1'h0;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic S_AXI_WVALID = 1'h0;
    logic S_AXI_BREADY = 1'h0;
    logic [11:0] S_AXI_ARADDR = 12'h0;
    logic S_AXI_ARVALID = 1'h0;
    logic S_AXI_RREADY = 1'h0;
    logic [63:0] TS_CLOCK = 64'h0;
    logic RX_PEND_CLR = 1'h0;
    logic TX_PEND_CLR = 1'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, FRAME_KIND;
    logic [31:0] S_AXI_RDATA;
    logic FRAME_VALID, FRAME_TX, RX_PEND, TX_PEND, COMPARE_EVENT;
    logic [47:0] FRAME_DEST;
    logic [79:0] FRAME_SRC_ID, RX_CAP_ID, TX_CAP_ID;
    logic [63:0] RX_CAP_CLOCK, TX_CAP_CLOCK;
    logic [15:0] FRAME_SEQ, RX_CAP_SEQ, TX_CAP_SEQ;
    logic [63:0] tgt;
    logic [63:0] ets [2]; // Expected captured clock, rx then tx
    // The four fixed multicast addresses, then the user address as written below
    logic [47:0] addr [5] = '{ADDR_PRI, ADDR_ALT_A, ADDR_ALT_B, ADDR_ALT_C, 48'h123456789ABC};
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    pscr_top u_dut (.CLOCK, .RSTN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
        .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
        .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TS_CLOCK, .FRAME_VALID,
        .FRAME_TX, .FRAME_KIND, .FRAME_DEST, .FRAME_SRC_ID, .FRAME_SEQ, .RX_PEND_CLR,
        .TX_PEND_CLR, .RX_PEND, .TX_PEND, .RX_CAP_CLOCK, .RX_CAP_ID, .RX_CAP_SEQ,
        .TX_CAP_CLOCK, .TX_CAP_ID, .TX_CAP_SEQ, .COMPARE_EVENT);
    pscr_frame_src u_src (.CLOCK, .FRAME_VALID, .FRAME_TX, .FRAME_KIND, .FRAME_DEST,
        .FRAME_SRC_ID, .FRAME_SEQ);

    // ----------------------------------------
    // Clock, running timestamp, watchdog
    // ----------------------------------------
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) TS_CLOCK <= TS_CLOCK + 64'h1;
    // Whole run needs under two thousand cycles; the ceiling leaves wide margin
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
        end while (S_AXI_BVALID !== 1'h1);
        S_AXI_BREADY <= 1'h0;
        chk(S_AXI_BRESP, RESP_OKAY);
    endtask
    // Read and compare data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
        end while (S_AXI_RVALID !== 1'h1);
        S_AXI_RREADY <= 1'h0;
        chk(S_AXI_RDATA, exp);
        chk(S_AXI_RRESP, er);
    endtask
    // Frame event, then pending flags and captured sequence checked
    task automatic fr(input logic tx, input logic [1:0] k, input logic [47:0] d,
                      input logic [15:0] s, input logic hit, input logic [15:0] es,
                      input logic clr);
        u_src.send(tx, k, d, s);
        #1;
        chk(RX_PEND, hit & ~tx);
        chk(TX_PEND, hit & tx);
        if (hit) chk(tx ? TX_CAP_SEQ : RX_CAP_SEQ, es);
        // A fresh capture took the clock one edge before this check
        if (hit && es == s) ets[tx] = TS_CLOCK - 64'h1;
        if (hit) chk(tx ? TX_CAP_CLOCK : RX_CAP_CLOCK, ets[tx]);
        if (hit) chk(tx ? TX_CAP_ID : RX_CAP_ID, {5{es}});
        if (clr) begin
            @(posedge CLOCK);
            RX_PEND_CLR <= 1'h1;
            TX_PEND_CLR <= 1'h1;
            @(posedge CLOCK);
            RX_PEND_CLR <= 1'h0;
            TX_PEND_CLR <= 1'h0;
        end
    endtask
    // Next compare event; TS_CLOCK has already moved one past the match
    task automatic wev(input logic [63:0] e);
        do begin
            @(posedge CLOCK);
            #1;
        end while (COMPARE_EVENT !== 1'h1);
        chk(TS_CLOCK - 64'h1, e);
    endtask
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge CLOCK);
        RSTN <= 1'h1;
        rd(OFF_CONFIG, 32'h43000000, RESP_OKAY);
        rd(OFF_RELOAD_LOW, 32'h0, RESP_OKAY);
        rd(OFF_ADDR_UPPER, 32'h0, RESP_OKAY);
        rd(OFF_ADDR_LOWER, 32'h0, RESP_OKAY);
        rd(12'h1FC, 32'h0, RESP_SLVERR);
        wr(OFF_ADDR_UPPER, 32'hFFFF1234);
        wr(OFF_ADDR_LOWER, 32'h56789ABC);
        rd(OFF_ADDR_UPPER, 32'h00001234, RESP_OKAY);
        rd(OFF_ADDR_LOWER, 32'h56789ABC, RESP_OKAY);
        // Reset config: locks hold the first capture while pending
        fr(0, MSG_SYNC, ADDR_PRI, 16'h1, 1, 16'h1, 0);
        rd(OFF_STATUS, 32'h1, RESP_OKAY);
        fr(0, MSG_SYNC, ADDR_PRI, 16'h2, 1, 16'h1, 1);
        fr(1, MSG_DELAY_REQ, ADDR_PRI, 16'h3, 1, 16'h3, 0);
        fr(1, MSG_DELAY_REQ, ADDR_PRI, 16'h4, 1, 16'h3, 1);
        wr(OFF_CONFIG, 32'h40000000);
        fr(0, MSG_SYNC, ADDR_PRI, 16'h5, 1, 16'h5, 0);
        fr(0, MSG_SYNC, ADDR_PRI, 16'h6, 1, 16'h6, 1);
        fr(1, MSG_DELAY_REQ, ADDR_PRI, 16'h7, 1, 16'h7, 0);
        fr(1, MSG_DELAY_REQ, ADDR_PRI, 16'h8, 1, 16'h8, 1);
        // One address enable at a time; the neighbouring address must miss
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CONFIG, 32'h1 << (30 - i));
            fr(0, MSG_SYNC, addr[i], 16'(i), 1, 16'(i), 1);
            fr(0, MSG_SYNC, addr[(i + 1) % 5], 16'h9, 0, 16'h9, 1);
        end
        wr(OFF_CONFIG, 32'h0);
        fr(0, MSG_SYNC, ADDR_PRI, 16'hA, 0, 16'hA, 1);
        // Master and slave direction over sync and delay request in both directions
        for (int m = 0; m < 2; m++) begin
            wr(OFF_CONFIG, m ? 32'hC0000000 : 32'h40000000);
            for (int t = 0; t < 2; t++) begin
                for (int k = 0; k < 2; k++) begin
                    fr(t[0], k[0] ? MSG_DELAY_REQ : MSG_SYNC, ADDR_PRI, 16'(k + 2 * t),
                       ~(m[0] ^ t[0] ^ k[0]), 16'(k + 2 * t), 1);
                end
            end
        end
        // Compare in add mode, a half-written reload, then reload mode
        wr(OFF_RELOAD_HIGH, 32'h0);
        wr(OFF_RELOAD_LOW, 32'h40);
        tgt = TS_CLOCK + 64'h64;
        wr(OFF_TARGET_HIGH, 32'h0);
        wr(OFF_TARGET_LOW, tgt[31:0]);
        wev(tgt);
        wev(tgt + 64'h40);
        wr(OFF_RELOAD_LOW, 32'hC8);
        wev(tgt + 64'h80);
        wr(OFF_RELOAD_HIGH, 32'h0);
        wev(tgt + 64'hC0);
        wr(OFF_RELOAD_LOW, 32'(tgt + 64'h3E8));
        wr(OFF_RELOAD_HIGH, 32'h0);
        wr(OFF_CONFIG, 32'h1);
        wev(tgt + 64'h188);
        wev(tgt + 64'h3E8);
        conclude();
    end
endmodule
`default_nettype wire
